// >>> counter_timer_pkg.sv
// Constants and types shared by the counter/timer and baud generator block.
package counter_timer_pkg;

  // ********************************************************************
  // Register offsets on the seven-bit host address.
  // ********************************************************************
  localparam logic [6:0] OFS_START_READ   = 7'h0e;
  localparam logic [6:0] OFS_STOP_READ    = 7'h0f;
  localparam logic [6:0] OFS_T0_HIGH      = 7'h16;
  localparam logic [6:0] OFS_T0_LOW       = 7'h17;
  localparam logic [6:0] OFS_T1_HIGH      = 7'h1e;
  localparam logic [6:0] OFS_T1_LOW       = 7'h1f;
  localparam logic [6:0] OFS_T0_MODE      = 7'h24;
  localparam logic [6:0] OFS_T1_MODE      = 7'h2c;
  localparam logic [6:0] OFS_B0_RLD_LOW   = 7'h26;
  localparam logic [6:0] OFS_B0_RLD_HIGH  = 7'h27;
  localparam logic [6:0] OFS_B1_RLD_LOW   = 7'h2e;
  localparam logic [6:0] OFS_B1_RLD_HIGH  = 7'h2f;
  localparam logic [6:0] OFS_BAUD_SRC     = 7'h33;
  localparam logic [6:0] OFS_STATUS       = 7'h3d;
  localparam logic [6:0] OFS_COMMAND      = 7'h3e;

  // ********************************************************************
  // Field positions.
  // ********************************************************************
  localparam int BAUD1_RUN_BIT   = 7;
  localparam int BAUD1_SEL_LSB   = 4;
  localparam int BAUD0_RUN_BIT   = 3;
  localparam int BAUD0_SEL_LSB   = 0;
  localparam int STAT_T0_RDY_BIT = 3;
  localparam int STAT_T1_RDY_BIT = 4;
  localparam int CMD_START0_BIT  = 0;
  localparam int CMD_STOP0_BIT   = 1;
  localparam int CMD_START1_BIT  = 2;
  localparam int CMD_STOP1_BIT   = 3;

  // ********************************************************************
  // Reset values and counts.
  // ********************************************************************
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [15:0] RST_WORD     = 16'h0000;
  localparam logic [3:0]  EXT_DIV_LAST = 4'hf;
  localparam logic [2:0]  DIV6_LAST    = 3'h5;

  // Counter/timer mode field codes.
  localparam logic [1:0] MODE_COUNTER = 2'h0;
  localparam logic [1:0] MODE_SQUARE  = 2'h1;
  localparam logic [1:0] MODE_PULSE   = 2'h3;

  // Counter/timer clock selection codes.
  localparam logic [3:0] TSEL_EXT     = 4'h0;
  localparam logic [3:0] TSEL_EXT16   = 4'h1;
  localparam logic [3:0] TSEL_SCLK    = 4'h2;
  localparam logic [3:0] TSEL_DIV2    = 4'h3;
  localparam logic [3:0] TSEL_DIV16   = 4'h4;
  localparam logic [3:0] TSEL_DIV32   = 4'h5;
  localparam logic [3:0] TSEL_DIV64   = 4'h6;
  localparam logic [3:0] TSEL_DIV128  = 4'h7;

  // Baud generator clock selection codes.
  localparam logic [2:0] BSEL_SCLK    = 3'h0;
  localparam logic [2:0] BSEL_DIV2    = 3'h1;
  localparam logic [2:0] BSEL_MID     = 3'h2;
  localparam logic [2:0] BSEL_DIV32   = 3'h3;
  localparam logic [2:0] BSEL_DIV64   = 3'h4;
  localparam logic [2:0] BSEL_DIV128  = 3'h5;
  localparam logic [2:0] BSEL_PIN     = 3'h6;

  // ********************************************************************
  // Carriers.
  // ********************************************************************
  typedef struct packed {
    logic [1:0] rsvd;
    logic [1:0] mode;
    logic [3:0] clk_sel;
  } tmr_ctl_t;

  typedef struct packed {
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [3:0] gpio;
  } pin_bundle_t;

  localparam pin_bundle_t PINS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                                        addr: 7'h00, wdata: 8'h00, gpio: 4'h0};

endpackage

// >>> counter_timer_and_baud_generator.sv
// Two counter/timers and two baud-rate generators behind the host register bus.
`timescale 1ns/100ps

// Contract
// - Count upper/lower locations read live counter bits 15:8 and 7:0.
// - Baud generator divides selected source by 16-bit reload, giving 16x clock.
// - Bit 7 runs generator 1, bit 3 runs generator 0; zero holds reset.
// - Bits 6:4 pick generator 1 source: clock, /2, /6, /32, /64, /128, pin 4.
// - Bits 2:0 pick generator 0 source: clock, /2, /16, /32, /64, /128, pin 3.
// - Presets are write-only; reads at shared addresses return the count.
// - Any 16-bit preset including zero is accepted.
// - Upper preset byte holds bits 15:8, lower holds bits 7:0.
// - Timer mode square wave period is twice the preset in prescaled clocks.
// - Pulse mode gives one pulse per preset interval, doubling the rate.
// - Timer preset change leaves current half-period alone; later ones use it.
// - Counter idles until start, by command or, for counter 0 only, read at 0x0E.
// - Start aborts current cycle and restarts from current preset.
// - Timer mode sets ready once per cycle; stop, or for counter 0 a read at 0x0F, clears it.
// - In timer mode stop clears ready only; wave keeps running.
// - Timer waveform is driven onto the counter output pin.
// - Counter mode counts down from preset, sets ready at zero, keeps counting.
// - Counter mode output stays high until zero, then goes low.
// - Counter mode stop returns output high and clears ready.
// - Counter mode new preset takes effect only at the next start.
// - External input divided by 16 allows total division up to 1,048,560.
// - Mode field 5:4: 00 counter, 01 square timer, 11 pulse timer.
// - Baud 0 divisor comes from upper reload byte 0x27 and lower byte 0x26; baud 1 from 0x2F and 0x2E.
module counter_timer_and_baud_generator (
  input  wire logic       REF_CLK,
  input  wire logic       RST,
  input  wire logic       CS_N,
  input  wire logic       RD_N,
  input  wire logic       WR_N,
  input  wire logic [6:0] ADDR,
  input  wire logic [7:0] DATA_IN,
  output logic      [7:0] DATA_OUT,
  output logic            DATA_OE_N,
  input  wire logic       GPIO2_IN,
  input  wire logic       GPIO7_IN,
  input  wire logic       GPIO3_IN,
  input  wire logic       GPIO4_IN,
  output logic            TIMER0_OUT,
  output logic            TIMER1_OUT,
  output logic      [1:0] TIMER_READY,
  output logic            BAUD0_16X,
  output logic            BAUD1_16X
);

  // ********************************************************************
  // Declarations.
  // ********************************************************************
  counter_timer_pkg::pin_bundle_t pin_s1_ff;
  counter_timer_pkg::pin_bundle_t pin_s2_ff;
  logic                           rd_prev_ff;
  logic                           wr_prev_ff;
  logic [3:0]                     gpio_prev_ff;
  logic                           rd_act;
  logic                           wr_act;
  logic                           rd_evt;
  logic                           wr_evt;
  logic [3:0]                     gpio_edge;
  logic [6:0]                     pre_ff;
  logic [2:0]                     div6_ff;
  counter_timer_pkg::tmr_ctl_t    tctl_ff [2];
  logic [15:0]                    preset_ff [2];
  logic [15:0]                    count_ff [2];
  logic [3:0]                     ext_div_ff [2];
  logic [1:0]                     run_ff;
  logic [1:0]                     wave_ff;
  logic [1:0]                     ready_ff;
  logic [1:0]                     start_cmd;
  logic [1:0]                     stop_cmd;
  logic [1:0]                     t_tick;
  logic [1:0]                     ready_set;
  logic [1:0]                     ext_edge;
  logic [7:0]                     bsrc_ff;
  logic [15:0]                    brld_ff [2];
  logic [15:0]                    bcount_ff [2];
  logic [1:0]                     b_tick;
  logic [1:0]                     b_out_ff;
  logic [1:0]                     b_run;
  logic [7:0]                     rd_mux;

  // True on the last clock of each 2^k prescaler period; k of zero is every clock.
  function automatic logic pow2_tick(input logic [6:0] pre, input logic [2:0] k);
    logic [7:0] m;
    m = (8'h01 << k) - 8'h01;
    return (pre & m[6:0]) == m[6:0];
  endfunction

  // ********************************************************************
  // Pin synchronisers.
  // ********************************************************************

  // Every host and GPIO pin passes two flops; only the second stage is read.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pin_s1_ff <= counter_timer_pkg::PINS_IDLE;
      pin_s2_ff <= counter_timer_pkg::PINS_IDLE;
    end else begin
      pin_s1_ff <= '{cs_n: CS_N, rd_n: RD_N, wr_n: WR_N, addr: ADDR, wdata: DATA_IN,
                     gpio: {GPIO4_IN, GPIO3_IN, GPIO7_IN, GPIO2_IN}};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // A third stage gives the previous level for edge detection.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rd_prev_ff   <= 1'b0;
      wr_prev_ff   <= 1'b0;
      gpio_prev_ff <= 4'h0;
    end else begin
      rd_prev_ff   <= rd_act;
      wr_prev_ff   <= wr_act;
      gpio_prev_ff <= pin_s2_ff.gpio;
    end
  end

  // Strobe activity and rising edges; the address and data are stable during a strobe.
  assign rd_act    = ~pin_s2_ff.cs_n & ~pin_s2_ff.rd_n;
  assign wr_act    = ~pin_s2_ff.cs_n & ~pin_s2_ff.wr_n;
  assign rd_evt    = rd_act & ~rd_prev_ff;
  assign wr_evt    = wr_act & ~wr_prev_ff;
  assign gpio_edge = pin_s2_ff.gpio & ~gpio_prev_ff;
  assign ext_edge  = {gpio_edge[1], gpio_edge[0]};

  // ********************************************************************
  // Prescalers.
  // ********************************************************************

  // Free-running dividers shared by all internal sources, so every internal selection is just an enable.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pre_ff  <= 7'h00;
      div6_ff <= 3'h0;
    end else begin
      pre_ff  <= pre_ff + 7'h01;
      div6_ff <= (div6_ff == counter_timer_pkg::DIV6_LAST) ? 3'h0 : div6_ff + 3'h1;
    end
  end

  // External edge counters divide a timer's pin input by 16.
  always_ff @(posedge REF_CLK) begin
    for (int i = 0; i < 2; i++) begin
      if (RST) begin
        ext_div_ff[i] <= 4'h0;
      end else if (ext_edge[i]) begin
        ext_div_ff[i] <= ext_div_ff[i] + 4'h1;
      end
    end
  end

  // Timer count enables; reserved selections never tick.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      unique case (tctl_ff[i].clk_sel)
        counter_timer_pkg::TSEL_EXT:    t_tick[i] = ext_edge[i];
        counter_timer_pkg::TSEL_EXT16:  t_tick[i] = ext_edge[i] &
                              (ext_div_ff[i] == counter_timer_pkg::EXT_DIV_LAST);
        counter_timer_pkg::TSEL_SCLK:   t_tick[i] = 1'b1;
        counter_timer_pkg::TSEL_DIV2:   t_tick[i] = pow2_tick(pre_ff, 3'h1);
        counter_timer_pkg::TSEL_DIV16:  t_tick[i] = pow2_tick(pre_ff, 3'h4);
        counter_timer_pkg::TSEL_DIV32:  t_tick[i] = pow2_tick(pre_ff, 3'h5);
        counter_timer_pkg::TSEL_DIV64:  t_tick[i] = pow2_tick(pre_ff, 3'h6);
        counter_timer_pkg::TSEL_DIV128: t_tick[i] = pow2_tick(pre_ff, 3'h7);
        default:                        t_tick[i] = 1'b0;
      endcase
    end
  end

  // ********************************************************************
  // Register writes and commands.
  // ********************************************************************

  // Presets are write-only: the shared addresses read back the count instead.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      preset_ff[0] <= counter_timer_pkg::RST_WORD;
      preset_ff[1] <= counter_timer_pkg::RST_WORD;
    end else if (wr_evt) begin
      unique case (pin_s2_ff.addr)
        counter_timer_pkg::OFS_T0_HIGH: preset_ff[0][15:8] <= pin_s2_ff.wdata;
        counter_timer_pkg::OFS_T0_LOW:  preset_ff[0][7:0]  <= pin_s2_ff.wdata;
        counter_timer_pkg::OFS_T1_HIGH: preset_ff[1][15:8] <= pin_s2_ff.wdata;
        counter_timer_pkg::OFS_T1_LOW:  preset_ff[1][7:0]  <= pin_s2_ff.wdata;
        default: ;
      endcase
    end
  end

  // Timer mode and clock selection registers.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      tctl_ff[0] <= counter_timer_pkg::RST_BYTE;
      tctl_ff[1] <= counter_timer_pkg::RST_BYTE;
    end else if (wr_evt && pin_s2_ff.addr == counter_timer_pkg::OFS_T0_MODE) begin
      tctl_ff[0] <= pin_s2_ff.wdata;
    end else if (wr_evt && pin_s2_ff.addr == counter_timer_pkg::OFS_T1_MODE) begin
      tctl_ff[1] <= pin_s2_ff.wdata;
    end
  end

  // Baud source, run bits and reload divisors.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      bsrc_ff    <= counter_timer_pkg::RST_BYTE;
      brld_ff[0] <= counter_timer_pkg::RST_WORD;
      brld_ff[1] <= counter_timer_pkg::RST_WORD;
    end else if (wr_evt) begin
      unique case (pin_s2_ff.addr)
        counter_timer_pkg::OFS_BAUD_SRC:    bsrc_ff            <= pin_s2_ff.wdata;
        counter_timer_pkg::OFS_B0_RLD_HIGH: brld_ff[0][15:8]   <= pin_s2_ff.wdata;
        counter_timer_pkg::OFS_B0_RLD_LOW:  brld_ff[0][7:0]    <= pin_s2_ff.wdata;
        counter_timer_pkg::OFS_B1_RLD_HIGH: brld_ff[1][15:8]   <= pin_s2_ff.wdata;
        counter_timer_pkg::OFS_B1_RLD_LOW:  brld_ff[1][7:0]    <= pin_s2_ff.wdata;
        default: ;
      endcase
    end
  end

  // Start and stop come from the command register or, for counter 0 only, from reads at the command addresses.
  always_comb begin
    start_cmd = 2'b00;
    stop_cmd  = 2'b00;
    if (rd_evt && pin_s2_ff.addr == counter_timer_pkg::OFS_START_READ) begin
      start_cmd[0] = 1'b1;
    end
    if (rd_evt && pin_s2_ff.addr == counter_timer_pkg::OFS_STOP_READ) begin
      stop_cmd[0] = 1'b1;
    end
    if (wr_evt && pin_s2_ff.addr == counter_timer_pkg::OFS_COMMAND) begin
      start_cmd[0] = start_cmd[0] | pin_s2_ff.wdata[counter_timer_pkg::CMD_START0_BIT];
      stop_cmd[0]  = stop_cmd[0]  | pin_s2_ff.wdata[counter_timer_pkg::CMD_STOP0_BIT];
      start_cmd[1] = pin_s2_ff.wdata[counter_timer_pkg::CMD_START1_BIT];
      stop_cmd[1]  = pin_s2_ff.wdata[counter_timer_pkg::CMD_STOP1_BIT];
    end
  end

  // ********************************************************************
  // Counter/timers.
  // ********************************************************************

  // Ready events: zero reached in counter mode, one per full wave, one per pulse.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      ready_set[i] = 1'b0;
      if (start_cmd[i]) begin
        ready_set[i] = (tctl_ff[i].mode == counter_timer_pkg::MODE_COUNTER) &&
                       (preset_ff[i] == 16'h0000);
      end else if (run_ff[i] && t_tick[i]) begin
        unique case (tctl_ff[i].mode)
          counter_timer_pkg::MODE_COUNTER: ready_set[i] = (count_ff[i] == 16'h0001);
          counter_timer_pkg::MODE_SQUARE:  ready_set[i] = (count_ff[i] <= 16'h0001) &
                                                           ~wave_ff[i];
          counter_timer_pkg::MODE_PULSE:   ready_set[i] = (count_ff[i] <= 16'h0001);
          default:                         ready_set[i] = 1'b0;
        endcase
      end
    end
  end

  // Count, run state and output wave of each counter/timer.
  always_ff @(posedge REF_CLK) begin
    for (int i = 0; i < 2; i++) begin
      if (RST) begin
        count_ff[i] <= counter_timer_pkg::RST_WORD;
        run_ff[i]   <= 1'b0;
        wave_ff[i]  <= 1'b1;
      end else if (start_cmd[i]) begin
        // Restart at once from the present preset, whatever was in progress.
        count_ff[i] <= preset_ff[i];
        run_ff[i]   <= 1'b1;
        wave_ff[i]  <= (tctl_ff[i].mode == counter_timer_pkg::MODE_PULSE) ? 1'b0 :
                       !((tctl_ff[i].mode == counter_timer_pkg::MODE_COUNTER) &&
                         (preset_ff[i] == 16'h0000));
      end else if (stop_cmd[i] && tctl_ff[i].mode == counter_timer_pkg::MODE_COUNTER) begin
        run_ff[i]   <= 1'b0;
        wave_ff[i]  <= 1'b1;
      end else if (run_ff[i] && t_tick[i]) begin
        unique case (tctl_ff[i].mode)
          counter_timer_pkg::MODE_COUNTER: begin
            // Counting runs on through zero; the output only falls there.
            count_ff[i] <= count_ff[i] - 16'h0001;
            if (count_ff[i] == 16'h0001) begin
              wave_ff[i] <= 1'b0;
            end
          end
          counter_timer_pkg::MODE_SQUARE: begin
            // The preset is sampled only at a half-period boundary.
            if (count_ff[i] <= 16'h0001) begin
              count_ff[i] <= preset_ff[i];
              wave_ff[i]  <= ~wave_ff[i];
            end else begin
              count_ff[i] <= count_ff[i] - 16'h0001;
            end
          end
          counter_timer_pkg::MODE_PULSE: begin
            // Pulse lasts one prescaled clock at the end of each interval.
            if (count_ff[i] <= 16'h0001) begin
              count_ff[i] <= preset_ff[i];
              wave_ff[i]  <= 1'b1;
            end else begin
              count_ff[i] <= count_ff[i] - 16'h0001;
              wave_ff[i]  <= 1'b0;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Ready is sticky; a new event in the cycle of a stop wins over the clear.
  always_ff @(posedge REF_CLK) begin
    for (int i = 0; i < 2; i++) begin
      if (RST) begin
        ready_ff[i] <= 1'b0;
      end else begin
        ready_ff[i] <= ready_set[i] | (ready_ff[i] & ~stop_cmd[i]);
      end
    end
  end

  // ********************************************************************
  // Baud generators.
  // ********************************************************************
  assign b_run = {bsrc_ff[counter_timer_pkg::BAUD1_RUN_BIT],
                  bsrc_ff[counter_timer_pkg::BAUD0_RUN_BIT]};

  // Source enables; the middle code differs between the two generators.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      unique case (i == 0 ? bsrc_ff[counter_timer_pkg::BAUD0_SEL_LSB +: 3] :
                            bsrc_ff[counter_timer_pkg::BAUD1_SEL_LSB +: 3])
        counter_timer_pkg::BSEL_SCLK:   b_tick[i] = 1'b1;
        counter_timer_pkg::BSEL_DIV2:   b_tick[i] = pow2_tick(pre_ff, 3'h1);
        counter_timer_pkg::BSEL_MID:    b_tick[i] = (i == 0) ? pow2_tick(pre_ff, 3'h4) :
                                          (div6_ff == counter_timer_pkg::DIV6_LAST);
        counter_timer_pkg::BSEL_DIV32:  b_tick[i] = pow2_tick(pre_ff, 3'h5);
        counter_timer_pkg::BSEL_DIV64:  b_tick[i] = pow2_tick(pre_ff, 3'h6);
        counter_timer_pkg::BSEL_DIV128: b_tick[i] = pow2_tick(pre_ff, 3'h7);
        counter_timer_pkg::BSEL_PIN:    b_tick[i] = gpio_edge[2 + i];
        default:                        b_tick[i] = 1'b0;
      endcase
    end
  end

  // Divide by the reload value; a stopped generator is held at its reload with no output.
  always_ff @(posedge REF_CLK) begin
    for (int i = 0; i < 2; i++) begin
      if (RST) begin
        bcount_ff[i] <= counter_timer_pkg::RST_WORD;
        b_out_ff[i]  <= 1'b0;
      end else if (!b_run[i]) begin
        bcount_ff[i] <= brld_ff[i];
        b_out_ff[i]  <= 1'b0;
      end else if (b_tick[i] && bcount_ff[i] <= 16'h0001) begin
        bcount_ff[i] <= brld_ff[i];
        b_out_ff[i]  <= 1'b1;
      end else begin
        bcount_ff[i] <= b_tick[i] ? bcount_ff[i] - 16'h0001 : bcount_ff[i];
        b_out_ff[i]  <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // Read path and outputs.
  // ********************************************************************

  // Read mux; count locations show the live counter, never the preset.
  always_comb begin
    unique case (pin_s2_ff.addr)
      counter_timer_pkg::OFS_T0_HIGH:     rd_mux = count_ff[0][15:8];
      counter_timer_pkg::OFS_T0_LOW:      rd_mux = count_ff[0][7:0];
      counter_timer_pkg::OFS_T1_HIGH:     rd_mux = count_ff[1][15:8];
      counter_timer_pkg::OFS_T1_LOW:      rd_mux = count_ff[1][7:0];
      counter_timer_pkg::OFS_T0_MODE:     rd_mux = tctl_ff[0];
      counter_timer_pkg::OFS_T1_MODE:     rd_mux = tctl_ff[1];
      counter_timer_pkg::OFS_B0_RLD_HIGH: rd_mux = brld_ff[0][15:8];
      counter_timer_pkg::OFS_B0_RLD_LOW:  rd_mux = brld_ff[0][7:0];
      counter_timer_pkg::OFS_B1_RLD_HIGH: rd_mux = brld_ff[1][15:8];
      counter_timer_pkg::OFS_B1_RLD_LOW:  rd_mux = brld_ff[1][7:0];
      counter_timer_pkg::OFS_BAUD_SRC:    rd_mux = bsrc_ff;
      counter_timer_pkg::OFS_STATUS: begin
        rd_mux = 8'h00;
        rd_mux[counter_timer_pkg::STAT_T0_RDY_BIT] = ready_ff[0];
        rd_mux[counter_timer_pkg::STAT_T1_RDY_BIT] = ready_ff[1];
      end
      default:                            rd_mux = 8'h00;
    endcase
  end

  // Data is refreshed every clock of a read, so a slow read can catch a carry.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      DATA_OUT  <= 8'h00;
      DATA_OE_N <= 1'b1;
    end else begin
      DATA_OUT  <= rd_act ? rd_mux : 8'h00;
      DATA_OE_N <= ~rd_act;
    end
  end

  // Registered copies of the waves, ready flags and baud pulses.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      TIMER0_OUT  <= 1'b1;
      TIMER1_OUT  <= 1'b1;
      TIMER_READY <= 2'b00;
      BAUD0_16X   <= 1'b0;
      BAUD1_16X   <= 1'b0;
    end else begin
      TIMER0_OUT  <= wave_ff[0];
      TIMER1_OUT  <= wave_ff[1];
      TIMER_READY <= ready_ff;
      BAUD0_16X   <= b_out_ff[0];
      BAUD1_16X   <= b_out_ff[1];
    end
  end

endmodule

// >>> counter_timer_sva.sv
// Port checker for the counter/timer block.
`timescale 1ns/100ps
module counter_timer_sva (
  input wire logic       REF_CLK,
  input wire logic       RST,
  input wire logic       CS_N,
  input wire logic       RD_N,
  input wire logic       WR_N,
  input wire logic [6:0] ADDR,
  input wire logic [7:0] DATA_OUT,
  input wire logic       DATA_OE_N,
  input wire logic       TIMER0_OUT,
  input wire logic       TIMER1_OUT,
  input wire logic [1:0] TIMER_READY
);
  // ****
  // Properties
  // ****
  // Strobes cross two sync flops, so a held strobe acts by its fourth sample.
  wire rd = !CS_N && !RD_N;
  wire wr = !CS_N && !WR_N;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  a_reset_vals: assert property ($fell(RST) |-> TIMER0_OUT && TIMER1_OUT && !TIMER_READY)
    else $error("bad reset state");
  a_read_drive: assert property (rd [*4] |-> !DATA_OE_N)
    else $error("read not answered");
  a_drive_cause: assert property (!DATA_OE_N |-> $past(rd, 3))
    else $error("bus driven unasked");
  a_idle_zero: assert property (CS_N [*4] |-> DATA_OE_N && DATA_OUT == 8'h00)
    else $error("idle bus not quiet");
  a_write_quiet: assert property (wr [*4] |-> DATA_OE_N)
    else $error("write drove bus");
  a_cmd_zero: assert property ((rd && ADDR inside {7'h0e, 7'h0f, 7'h3e}) [*4] |->
    DATA_OUT == 8'h00) else $error("command read not zero");
  a_status_bits: assert property ((rd && ADDR == 7'h3d) [*4] |->
    DATA_OUT == {3'h0, TIMER_READY, 3'h0}) else $error("status bits wrong");
  a_ready0_hold: assert property ($fell(TIMER_READY[0]) && !$past(RST) |-> !$past(CS_N, 3))
    else $error("ready 0 fell alone");
  a_ready1_hold: assert property ($fell(TIMER_READY[1]) && !$past(RST) |-> !$past(CS_N, 3))
    else $error("ready 1 fell alone");
endmodule
bind counter_timer_and_baud_generator counter_timer_sva u_sva (.REF_CLK(REF_CLK), .RST(RST),
  .CS_N(CS_N), .RD_N(RD_N), .WR_N(WR_N), .ADDR(ADDR), .DATA_OUT(DATA_OUT),
  .DATA_OE_N(DATA_OE_N), .TIMER0_OUT(TIMER0_OUT), .TIMER1_OUT(TIMER1_OUT),
  .TIMER_READY(TIMER_READY));

// >>> host_bus_model.sv
// Host processor model driving the register bus.
`timescale 1ns/100ps
module host_bus_model (
  input  wire logic                      clk,
  input  wire logic [7:0]                rdata,
  input  wire logic                      oe_n,
  output counter_timer_pkg::pin_bundle_t pins,
  output logic                           hung
);
  // ****
  // Bus cycles
  // ****
  // Idle bus from time zero.
  initial begin
    pins = counter_timer_pkg::PINS_IDLE;
    hung = 1'b0;
  end
  // Strobe held four samples so the sync flops see it; reads wait for the drive enable.
  task automatic xfer(input logic r, input logic [6:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    int n;
    @(posedge clk);
    pins <= '{1'b0, !r, r, a, d, pins.gpio};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (n < 4 || (r && oe_n !== 1'b0 && n < 12));
    q = rdata;
    if (n == 12) hung <= 1'b1;
    // Released lines show the inverse so stale values cannot pass.
    pins <= '{1'b1, 1'b1, 1'b1, ~a, ~d, pins.gpio};
    repeat (3) @(posedge clk);
  endtask
endmodule

// >>> tb.sv
// Self-checking testbench for the counter/timer block.
`timescale 1ns/100ps
module tb;
  counter_timer_pkg::pin_bundle_t pins;
  logic                           REF_CLK, RST, oe_n, t0, t1, b0, b1, hung;
  logic [7:0]                     dout, q, lo;
  logic [1:0]                     rdy;
  int                             fails, total_checks, n;
  counter_timer_and_baud_generator u_counter_timer_and_baud_generator (.REF_CLK(REF_CLK),
    .RST(RST), .CS_N(pins.cs_n), .RD_N(pins.rd_n), .WR_N(pins.wr_n), .ADDR(pins.addr),
    .DATA_IN(pins.wdata), .DATA_OUT(dout), .DATA_OE_N(oe_n), .GPIO2_IN(pins.gpio[0]),
    .GPIO7_IN(pins.gpio[1]), .GPIO3_IN(pins.gpio[2]), .GPIO4_IN(pins.gpio[3]),
    .TIMER0_OUT(t0), .TIMER1_OUT(t1), .TIMER_READY(rdy), .BAUD0_16X(b0), .BAUD1_16X(b1));
  host_bus_model u_host (.clk(REF_CLK), .rdata(dout), .oe_n(oe_n), .pins(pins), .hung(hung));
  // ****
  // Helpers
  // ****
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_host.xfer(1'b0, a, d, q);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    u_host.xfer(1'b1, a, 8'h00, q);
    chk(q, e);
  endtask
  // Cycles between two rising edges of a timer or baud output; bounded.
  task automatic meas(input int k, output int p);
    int r;
    logic v, pv;
    r = 0;
    p = 0;
    pv = 1'b1;
    for (int i = 0; i < 400 && r < 2; i++) begin
      @(posedge REF_CLK);
      v = k == 0 ? t0 : (k == 1 ? b0 : b1);
      if (r > 0) p++;
      if (v === 1'b1 && pv === 1'b0) r++;
      pv = v;
    end
    if (r < 2) begin
      fails++;
      close_out();
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // The clock and the hang guard.
  initial begin
    REF_CLK = 1'b0;
    forever #12.5 REF_CLK = ~REF_CLK;
  end
  always @(posedge hung) begin
    fails++;
    close_out();
  end
  // Scenario sequence.
  initial begin
    fails = 0;
    total_checks = 0;
    RST = 1'b1;
    repeat (5) @(posedge REF_CLK);
    RST <= 1'b0;
    wr(7'h24, 8'h02);
    wr(7'h17, 8'h40);
    rd(7'h17, 8'h00);
    rd(7'h0e, 8'h00);
    repeat (80) @(posedge REF_CLK);
    chk({rdy[0], t0}, 2'b10);
    rd(7'h16, 8'hff);
    rd(7'h0f, 8'h00);
    chk({rdy[0], t0}, 2'b01);
    u_host.xfer(1'b1, 7'h17, 8'h00, lo);
    wr(7'h17, 8'h55);
    rd(7'h17, lo);
    rd(7'h0e, 8'h00);
    rd(7'h16, 8'h00);
    wr(7'h24, 8'h12);
    wr(7'h17, 8'h05);
    wr(7'h3e, 8'h01);
    meas(0, n);
    chk(n, 10);
    wr(7'h17, 8'h03);
    meas(0, n);
    chk(n, 6);
    wr(7'h3e, 8'h02);
    meas(0, n);
    chk(n, 6);
    wr(7'h24, 8'h32);
    meas(0, n);
    chk(n, 3);
    wr(7'h24, 8'h22);
    wr(7'h3e, 8'h02);
    wr(7'h2c, 8'h02);
    wr(7'h1f, 8'h00);
    wr(7'h3e, 8'h04);
    chk({rdy, t1}, 3'b100);
    rd(7'h3d, 8'h10);
    wr(7'h3e, 8'h08);
    chk({rdy, t1}, 3'b001);
    rd(7'h3e, 8'h00);
    wr(7'h26, 8'h04);
    wr(7'h33, 8'h08);
    meas(1, n);
    chk(n, 4);
    wr(7'h2e, 8'h02);
    wr(7'h33, 8'h9a);
    rd(7'h33, 8'h9a);
    meas(2, n);
    chk(n, 4);
    wr(7'h26, 8'h01);
    meas(1, n);
    chk(n, 16);
    // Generator 1 on its odd middle source: divisor 2 of a /6 source gives 12 clocks.
    wr(7'h33, 8'ha0);
    meas(2, n);
    chk(n, 12);
    close_out();
  end
endmodule
